// File: inc/brd_pkg.sv
package brd_pkg;
   // width of the protected register banks
   localparam int         DATA_W        = 8;
   // number of registers cleared by the bus reset
   localparam int         CFG_DEPTH     = 4;
   // number of registers holding wake-event context
   localparam int         PME_DEPTH     = 2;
   localparam int         ADDR_W        = 3;
   // reset value of every register
   localparam logic [7:0] REG_RST_VAL   = 8'h00;
   // address at and above which the wake-context bank starts
   localparam logic [2:0] PME_BASE      = 3'h4;
   // index of the wake-event flag bit inside the context bank
   localparam int         PME_FLAG_BIT  = 0;
   // release-counter value that ends the wait after either reset is released
   localparam logic [1:0] RELEASE_CYC   = 2'h2;

   // states of the sequencer that sees both reset sources together
   typedef enum logic [1:0] {
      BRD_RUN,
      BRD_HOLD,
      BRD_RELEASE
   } brd_state_t;

   // true for an address inside the wake-context bank
   function automatic logic brd_is_pme(input logic [2:0] addr);
      return addr >= PME_BASE;
   endfunction
endpackage

// File: verif/brd_host_model.sv
// host reset logic: drives both reset sources and retention
module brd_host_model (
   input  wire logic i_clk,
   output logic      o_global_reset_in_b,
   output logic      o_bus_reset_in_b,
   output logic      o_retain
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_global_reset_in_b = 1'b0;
      o_bus_reset_in_b    = 1'b0;
      o_retain            = 1'b0;
      repeat (3) @(negedge i_clk);
      o_global_reset_in_b = 1'b1;
      o_bus_reset_in_b    = 1'b1;
   end
   // later bus reset; global kept only for test cases
   task automatic hold(input logic glob, input logic keep, input int n);
      @(negedge i_clk);
      o_retain = keep;
      @(negedge i_clk);
      if (glob) o_global_reset_in_b = 1'b0;
      else o_bus_reset_in_b = 1'b0;
      repeat (n) @(negedge i_clk);
      o_global_reset_in_b = 1'b1;
      o_bus_reset_in_b    = 1'b1;
      // retention outlives the release so the clear cannot slip in
      repeat (2) @(negedge i_clk);
      o_retain = 1'b0;
   endtask
endmodule

// File: verif/bus_controller_reset_domains_tb.sv
module bus_controller_reset_domains_tb;
   import brd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst_b, req, wr, pme_ev, ack, roe, pme, pme_oe, active;
   logic              g_b, p_b, retain;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [7:0]        mdl [6];
   int                n_fail, checks;

   brd_host_model u_host (.i_clk(clk), .o_global_reset_in_b(g_b),
      .o_bus_reset_in_b(p_b), .o_retain(retain));
   brd_reset_ctrl u_dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1),
      .I_GLOBAL_RESET_IN_B(g_b), .I_BUS_RESET_IN_B(p_b), .I_RETAIN(retain),
      .I_REQ(req), .I_WR(wr), .I_ADDR(addr), .I_WDATA(wdata),
      .I_PME_EVENT(pme_ev), .O_ACK(ack), .O_RDATA(rdata), .O_RDATA_OE(roe),
      .O_PME(pme), .O_PME_OE(pme_oe), .O_ACTIVE(active));

   task automatic tally_and_finish();
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one transaction, answer stands one cycle, two edges after the request
   task automatic op(input logic w, input int a, input logic [7:0] d, input logic up);
      @(negedge clk);
      req   = 1'b1;
      wr    = w;
      addr  = a[ADDR_W-1:0];
      wdata = d;
      @(negedge clk);
      req = 1'b0;
      @(negedge clk);
      cmp({7'h0, ack}, {7'h0, up});
      cmp({7'h0, roe}, {7'h0, up && !w});
      cmp(rdata, (up && !w) ? mdl[a] : 8'h00);
      if (w && up) mdl[a] = d;
   endtask
   task automatic wait_active();
      for (int i = 0; i < 20 && active !== 1'b1; i++) @(negedge clk);
      cmp({7'h0, active}, 8'h01);
   endtask
   task automatic fill_and_read(input logic w);
      for (int a = 0; a < 6; a++) op(w, a, 8'($urandom), 1'b1);
   endtask
   task automatic rst_case(input logic glob, input logic keep);
      fill_and_read(1'b1);
      fork
         u_host.hold(glob, keep, 6);
         begin
            repeat (5) @(negedge clk);
            cmp({5'h0, pme_oe, roe, active}, 8'h00);
            op(1'b0, 1, 8'h00, 1'b0);
         end
      join
      if (!keep) for (int a = 0; a < 6; a++) if (glob || a < 4) mdl[a] = REG_RST_VAL;
      wait_active();
      fill_and_read(1'b0);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h0d2aa742));
      {rst_b, req, wr, pme_ev, addr, wdata} = '0;
      n_fail = 0;
      checks = 0;
      foreach (mdl[i]) mdl[i] = REG_RST_VAL;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      wait_active();
      fill_and_read(1'b1);
      @(negedge clk);
      pme_ev = 1'b1;
      @(negedge clk);
      pme_ev = 1'b0;
      mdl[4][0] = 1'b1;
      repeat (3) @(negedge clk);
      cmp({6'h0, pme_oe, pme}, 8'h03);
      fill_and_read(1'b0);
      rst_case(1'b0, 1'b0);
      rst_case(1'b0, 1'b1);
      rst_case(1'b1, 1'b1);
      rst_case(1'b1, 1'b0);
      tally_and_finish();
   end
endmodule

// File: verilog/brd_reg_bank.sv
// one bank of registers with a qualified synchronous clear
module brd_reg_bank #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 8
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_b,
   input  wire logic                         i_ce,
   input  wire logic                         i_clear,
   input  wire logic                         i_we,
   input  wire logic [$clog2(DEPTH)-1:0]     i_idx,
   input  wire logic [WIDTH-1:0]             i_wdata,
   input  wire logic [$clog2(DEPTH)-1:0]     i_ridx,
   output logic      [WIDTH-1:0]             o_rdata
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int k = 0; k < DEPTH; k++) begin
            mem_r[k] <= '0;
         end
      end else if (i_ce) begin
         if (i_clear) begin
            for (int k = 0; k < DEPTH; k++) begin
               mem_r[k] <= '0;
            end
         end else if (i_we) begin
            mem_r[i_idx] <= i_wdata;
         end
      end
   end

   assign o_rdata = mem_r[i_ridx];
endmodule

// File: verilog/brd_reset_ctrl.sv
// How it works
// - global reset floats outputs, clears registers
// - global reset holds whole device default
// - later resets use bus reset, keeping wake
// - retention blocks global clear, outputs float
// - all bus inputs sampled on rising clock
// - bus reset floats outputs, clears config bank
// - no transactions accepted during bus reset
// - after bus reset, config bank starts from defaults
// - retention plus bus reset keeps registers
module brd_reset_ctrl
   import brd_pkg::*;
#(
   parameter int WIDTH = brd_pkg::DATA_W
) (
   // clock, power-on reset, enable
   input  wire logic                 I_SYS_CLK,
   input  wire logic                 I_RST_B,
   input  wire logic                 I_CE,
   // reset sources, active low, and retention
   input  wire logic                 I_GLOBAL_RESET_IN_B,
   input  wire logic                 I_BUS_RESET_IN_B,
   input  wire logic                 I_RETAIN,
   // simple transaction port
   input  wire logic                 I_REQ,
   input  wire logic                 I_WR,
   input  wire logic [brd_pkg::ADDR_W-1:0] I_ADDR,
   input  wire logic [WIDTH-1:0]     I_WDATA,
   // wake event from the card side
   input  wire logic                 I_PME_EVENT,
   // outputs with enables
   output logic                      O_ACK,
   output logic      [WIDTH-1:0]     O_RDATA,
   output logic                      O_RDATA_OE,
   output logic                      O_PME,
   output logic                      O_PME_OE,
   output logic                      O_ACTIVE
);
   import brd_pkg::*;

   brd_state_t       state_r;
   brd_state_t       state_nxt;
   logic             glob_rst_r;
   logic             bus_rst_r;
   logic             pme_flag_r;
   logic             retain_r;
   logic             req_r;
   logic             wr_r;
   logic [ADDR_W-1:0] addr_r;
   logic [WIDTH-1:0] wdata_r;
   logic             pme_ev_r;
   logic [1:0]       rel_cnt_r;
   logic             any_rst;
   logic             run;
   logic             cfg_clear;
   logic             pme_clear;
   logic             acc;
   logic [WIDTH-1:0] cfg_rd;
   logic [WIDTH-1:0] pme_rd;
   logic [WIDTH-1:0] pme_wd;
   logic             pme_we;

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         glob_rst_r <= 1'b1;
         bus_rst_r  <= 1'b1;
         retain_r <= 1'b0;
         req_r    <= 1'b0;
         wr_r     <= 1'b0;
         addr_r   <= '0;
         wdata_r  <= '0;
         pme_ev_r <= 1'b0;
      end else if (I_CE) begin
         glob_rst_r <= !I_GLOBAL_RESET_IN_B;
         bus_rst_r  <= !I_BUS_RESET_IN_B;
         retain_r <= I_RETAIN;
         req_r    <= I_REQ;
         wr_r     <= I_WR;
         addr_r   <= I_ADDR;
         wdata_r  <= I_WDATA;
         pme_ev_r <= I_PME_EVENT;
      end
   end

   assign any_rst = glob_rst_r || bus_rst_r;
   assign cfg_clear = any_rst && !retain_r;
   assign pme_clear = glob_rst_r && !retain_r;
   // no work while held in reset
   assign run = (state_r == BRD_RUN) && !any_rst;
   assign acc = run && req_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         BRD_RUN:     if (any_rst) state_nxt = BRD_HOLD;
         BRD_HOLD:    if (!any_rst) state_nxt = BRD_RELEASE;
         BRD_RELEASE: begin
            if (any_rst) begin
               state_nxt = BRD_HOLD;
            end else if (rel_cnt_r == RELEASE_CYC) begin
               state_nxt = BRD_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_r <= BRD_HOLD;
      end else if (I_CE) begin
         state_r <= state_nxt;
      end
   end

   // short settle time before serving after release
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rel_cnt_r <= '0;
      end else if (I_CE) begin
         if (state_r == BRD_RELEASE && !any_rst) begin
            rel_cnt_r <= rel_cnt_r + 2'h1;
         end else begin
            rel_cnt_r <= '0;
         end
      end
   end

   brd_reg_bank #(.DEPTH(CFG_DEPTH), .WIDTH(WIDTH)) u_cfg (
      .i_clk   (I_SYS_CLK),
      .i_rst_b (I_RST_B),
      .i_ce    (I_CE),
      .i_clear (cfg_clear),
      .i_we    (acc && wr_r && !brd_is_pme(addr_r)),
      .i_idx   (addr_r[1:0]),
      .i_wdata (wdata_r),
      .i_ridx  (addr_r[1:0]),
      .o_rdata (cfg_rd)
   );

   // wake flag sets even outside run, set wins over write
   // limitation: a write to the second wake word is lost under an event
   always_comb begin
      pme_wd = (acc && wr_r && brd_is_pme(addr_r) && !(pme_ev_r && addr_r[0])) ?
               wdata_r : pme_rd;
      if (pme_ev_r) begin
         pme_wd[PME_FLAG_BIT] = 1'b1;
      end
   end
   assign pme_we = (acc && wr_r && brd_is_pme(addr_r)) || pme_ev_r;

   // only global reset clears wake bank
   brd_reg_bank #(.DEPTH(PME_DEPTH), .WIDTH(WIDTH)) u_pme (
      .i_clk   (I_SYS_CLK),
      .i_rst_b (I_RST_B),
      .i_ce    (I_CE),
      .i_clear (pme_clear),
      .i_we    (pme_we),
      .i_idx   (pme_ev_r ? 1'b0 : addr_r[0]),
      .i_wdata (pme_wd),
      .i_ridx  (pme_ev_r ? 1'b0 : addr_r[0]),
      .o_rdata (pme_rd)
   );

   // mirror of the wake flag so the pin never follows the read index
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pme_flag_r <= 1'b0;
      end else if (I_CE) begin
         if (pme_clear) begin
            pme_flag_r <= 1'b0;
         end else if (pme_ev_r) begin
            pme_flag_r <= 1'b1;
         end else if (acc && wr_r && addr_r == PME_BASE) begin
            pme_flag_r <= wdata_r[PME_FLAG_BIT];
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_ACK      <= 1'b0;
         O_RDATA    <= REG_RST_VAL;
         O_RDATA_OE <= 1'b0;
         O_PME      <= 1'b0;
         O_PME_OE   <= 1'b0;
         O_ACTIVE   <= 1'b0;
      end else if (I_CE) begin
         O_ACK      <= acc;
         O_RDATA    <= (acc && !wr_r) ?
                       (brd_is_pme(addr_r) ? pme_rd : cfg_rd) : REG_RST_VAL;
         O_RDATA_OE <= acc && !wr_r;
         O_PME      <= run && pme_flag_r;
         O_PME_OE   <= run;
         O_ACTIVE   <= run;
      end
   end

   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_B);

   AST_FLOAT_GLOBAL: assert property (
      I_CE && glob_rst_r |=> !O_RDATA_OE && !O_PME_OE)
      else $error("outputs driven during global reset");
   AST_NO_ACK_BUS: assert property (
      I_CE && bus_rst_r |=> !O_ACK)
      else $error("ack during bus reset");
   AST_FLOAT_BUS: assert property (
      I_CE && bus_rst_r |=> !O_ACTIVE && !O_RDATA_OE)
      else $error("outputs driven during bus reset");
   AST_REL_WAIT: assert property (
      I_CE && $fell(any_rst) |=> !O_ACTIVE)
      else $error("active too early after release");
   AST_RETAIN_CFG: assert property (
      I_CE && any_rst && retain_r |=> $stable(u_cfg.mem_r[0]))
      else $error("config lost under retention");
   AST_RETAIN_GLOBAL: assert property (
      I_CE && glob_rst_r && retain_r |=> $stable(u_pme.mem_r[0]))
      else $error("wake bank lost under retention");
   AST_PME_KEEP: assert property (
      I_CE && bus_rst_r && !glob_rst_r && !pme_ev_r |=> $stable(u_pme.mem_r[0]))
      else $error("bus reset cleared wake bank");
   AST_GLOBAL_CLR: assert property (
      I_CE && glob_rst_r && !retain_r |=> u_pme.mem_r[0] == '0 && u_cfg.mem_r[0] == '0)
      else $error("global reset left state");
   AST_SAMPLE: assert property (
      I_CE && !I_BUS_RESET_IN_B |=> bus_rst_r)
      else $error("bus reset not sampled");

   COV_ACCESS: cover property (acc && !wr_r);
   COV_BUS_RETAIN: cover property (bus_rst_r && retain_r);
   COV_WAKE_KEEP: cover property (bus_rst_r && u_pme.mem_r[0] != '0);
endmodule
